/* hdl/fwcc_pkg.sv */
// Constants, register map and types of the fail-safe, watchdog and clear/force control block.
// Assumes a single 100 MHz system clock and a 32-bit classic Wishbone register port.
package fwcc_pkg;
    localparam int ADR_W = 10;
    localparam int DAT_W = 32;
    localparam int REG_W = 8;
    localparam int IDX_W = 8;

    // Timing: clock period and derived cycles per microsecond tick
    localparam int unsigned CLK_PERIOD_PS = 10000;
    localparam int unsigned PS_PER_US = 1000000;
    localparam int unsigned US_TICK_CYCLES = PS_PER_US / CLK_PERIOD_PS;

    // Register indexes; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_WDOG = 8'h5a;
    localparam logic [IDX_W-1:0] IDX_SHORT = 8'h5b;
    localparam logic [IDX_W-1:0] IDX_CLR = 8'h60;
    localparam logic [IDX_W-1:0] IDX_LOCK = 8'h61;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 8'h70;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h71;
    localparam logic [IDX_W-1:0] IDX_STATE = 8'h72;

    // Watchdog select field sits in bits 7:4
    localparam int WDSEL_LSB = 4;
    localparam int WDSEL_W = 4;
    localparam logic [WDSEL_W-1:0] WD_OFF = 4'h0;
    localparam logic [WDSEL_W-1:0] WD_DIRECT_MIN = 4'hc;

    // Clear/force register bit positions
    localparam int CLR_FORCE_FS = 5;
    localparam int CLR_RESTORE = 4;
    localparam int CLR_FORCE_ERR = 3;
    localparam int CLR_LEAVE_FS = 2;
    localparam int CLR_FAULTS = 1;
    localparam int CLR_POWER_ON = 0;

    localparam int LOCK_CLR_BIT = 3;
    localparam logic LOCK_RESET = 1'b1;
    localparam logic POR_RESET = 1'b1;

    // Interrupt status / mask layout
    localparam int IRQ_W = 3;
    localparam int IRQ_FS_ENTER = 0;
    localparam int IRQ_FAULT = 1;
    localparam int IRQ_WDOG = 2;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

    // State register layout
    localparam int ST_FAILSAFE = 0;
    localparam int ST_FAULT = 1;
    localparam int ST_POR = 2;
    localparam int ST_ERR_PIN = 3;

    // Watchdog timeouts in microseconds for codes 1h..Bh
    localparam int US_W = 19;
    localparam logic [US_W-1:0] WD_TIME_US [1:11] = '{
        19'd200, 19'd500, 19'd1000, 19'd2000, 19'd5000, 19'd10000,
        19'd20000, 19'd50000, 19'd100000, 19'd200000, 19'd500000};

    typedef enum logic {FWCC_NORMAL, FWCC_FAILSAFE} fwcc_state_t;
endpackage

/* hdl/fwcc_wd_timer.sv */
// Watchdog timer: microsecond prescaler and timeout counter.
// Assumes restart and enable come from logic on the same clock.
`timescale 1ns/1ps
module fwcc_wd_timer #(
    parameter int unsigned TICK_CYCLES = fwcc_pkg::US_TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic restart,
    input wire logic [fwcc_pkg::US_W-1:0] limit_us,
    output logic expired
);
    import fwcc_pkg::*;

    logic [15:0] tick_cnt;
    logic [US_W-1:0] us_cnt;
    logic fired;
    wire hold_off = !enable || restart;
    wire tick = (tick_cnt == 16'(TICK_CYCLES - 1));
    wire reach = tick && (us_cnt + 19'h1 >= limit_us) && !fired;

    // Expiry fires once, then waits for a restart
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= 16'h0;
            us_cnt <= 19'h0;
            fired <= 1'b0;
            expired <= 1'b0;
        end else if (hold_off) begin
            tick_cnt <= 16'h0;
            us_cnt <= 19'h0;
            fired <= 1'b0;
            expired <= 1'b0;
        end else begin
            tick_cnt <= tick ? 16'h0 : tick_cnt + 16'h1;
            if (tick && !fired) begin
                us_cnt <= us_cnt + 19'h1;
            end
            fired <= fired || reach;
            expired <= reach;
        end
    end
endmodule // fwcc_wd_timer

/* hdl/fwcc_ctrl.sv */
// Fail-safe state, watchdog and clear/force control registers behind classic Wishbone.
// Assumes a 32-bit single-cycle master, data in byte lane 0, and same-clock fault events.
`timescale 1ns/1ps
module fwcc_ctrl #(
    parameter int unsigned TICK_CYCLES = fwcc_pkg::US_TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [fwcc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [fwcc_pkg::DAT_W-1:0] wb_dat_i,
    output logic [fwcc_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [fwcc_pkg::REG_W-1:0] stored_short_threshold,
    input wire logic [fwcc_pkg::WDSEL_W-1:0] stored_watchdog_select,
    input wire logic fault_event,
    input wire logic err_pin_in,
    output logic err_pin_out,
    output logic err_pin_oe,
    output logic failsafe_active,
    output logic [fwcc_pkg::REG_W-1:0] adc_short_threshold,
    output logic restore_defaults_pulse,
    output logic irq
);
    import fwcc_pkg::*;

    fwcc_state_t state;
    fwcc_state_t next_state;
    logic [WDSEL_W-1:0] watchdog_timeout_select;
    logic clear_register_lock;
    logic load_pending;
    logic fault_flag;
    logic power_on_flag;
    logic force_err_hold;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [2:0] err_sync;
    logic err_level;
    logic wd_expired;

    // Bus decode
    wire [IDX_W-1:0] idx = wb_adr_i[ADR_W-1:2];
    wire bus_take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_take = bus_take && wb_we_i && wb_sel_i[0];
    wire rd_take = bus_take && !wb_we_i;
    wire [REG_W-1:0] wdat = wb_dat_i[REG_W-1:0];
    wire wr_wdog = wr_take && (idx == IDX_WDOG);
    wire wr_short = wr_take && (idx == IDX_SHORT);
    wire wr_clr = wr_take && (idx == IDX_CLR);
    wire wr_lock = wr_take && (idx == IDX_LOCK);
    wire wr_mask = wr_take && (idx == IDX_IRQ_MASK);
    wire rd_stat = rd_take && (idx == IDX_IRQ_STAT);

    // Command strobes, one per accepted write
    wire clr_ok = wr_clr && !clear_register_lock;
    wire force_fs_cmd = clr_ok && wdat[CLR_FORCE_FS];
    wire restore_cmd = clr_ok && wdat[CLR_RESTORE];
    wire force_err_cmd = clr_ok && wdat[CLR_FORCE_ERR];
    wire leave_fs_cmd = clr_ok && wdat[CLR_LEAVE_FS];
    wire clear_fault_flags_cmd = clr_ok && wdat[CLR_FAULTS];
    wire clear_power_on_flag_cmd = clr_ok && wdat[CLR_POWER_ON];

    // Watchdog decode
    wire wd_off = (watchdog_timeout_select == WD_OFF);
    wire wd_direct = (watchdog_timeout_select >= WD_DIRECT_MIN);
    wire [US_W-1:0] wd_limit = (wd_off || wd_direct) ? 19'h0 :
        WD_TIME_US[watchdog_timeout_select];
    wire wd_enable = !wd_off && !wd_direct && (state == FWCC_NORMAL);

    fwcc_wd_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_wd_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .enable(wd_enable),
        .restart(bus_take),
        .limit_us(wd_limit),
        .expired(wd_expired)
    );

    // A forced entry beats a leave written in the same cycle
    wire enter_req = force_fs_cmd || wd_direct || (wd_expired && !bus_take);
    assign next_state = (state == FWCC_NORMAL) ?
        (enter_req ? FWCC_FAILSAFE : FWCC_NORMAL) :
        ((leave_fs_cmd && !force_fs_cmd) ? FWCC_NORMAL : FWCC_FAILSAFE);
    wire fs_enter = (state == FWCC_NORMAL) && (next_state == FWCC_FAILSAFE);

    // Interrupt events; a set in the clearing cycle survives
    wire [IRQ_W-1:0] irq_set = {wd_expired && (state == FWCC_NORMAL), fault_event, fs_enter};
    wire [IRQ_W-1:0] next_irq_stat = (rd_stat ? {IRQ_W{1'b0}} : irq_stat) | irq_set;

    // Read mux; command bits always read as zero
    wire [REG_W-1:0] rd_val =
        (idx == IDX_WDOG) ? {watchdog_timeout_select, 4'h0} :
        (idx == IDX_SHORT) ? adc_short_threshold :
        (idx == IDX_LOCK) ? REG_W'({clear_register_lock, 3'h0}) :
        (idx == IDX_IRQ_STAT) ? REG_W'(irq_stat) :
        (idx == IDX_IRQ_MASK) ? REG_W'(irq_mask) :
        (idx == IDX_STATE) ? REG_W'({err_level, power_on_flag, fault_flag,
                                     state == FWCC_FAILSAFE}) :
        8'h0;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= bus_take;
            wb_dat_o <= rd_take ? DAT_W'(rd_val) : 32'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= FWCC_NORMAL;
            failsafe_active <= 1'b0;
        end else begin
            state <= next_state;
            failsafe_active <= (next_state == FWCC_FAILSAFE);
        end
    end

    // Nonvolatile-backed fields load once after reset release and again on each restore command
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            load_pending <= 1'b1;
            adc_short_threshold <= 8'h0;
            watchdog_timeout_select <= 4'h0;
        end else begin
            load_pending <= 1'b0;
            if (load_pending || restore_cmd) begin
                adc_short_threshold <= stored_short_threshold;
                watchdog_timeout_select <= stored_watchdog_select;
            end else begin
                if (wr_short) begin
                    adc_short_threshold <= wdat;
                end
                if (wr_wdog) begin
                    watchdog_timeout_select <= wdat[WDSEL_LSB +: WDSEL_W];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clear_register_lock <= LOCK_RESET;
            irq_mask <= IRQ_MASK_RESET;
        end else if (restore_cmd) begin
            clear_register_lock <= LOCK_RESET;
            irq_mask <= IRQ_MASK_RESET;
        end else begin
            if (wr_lock) begin
                clear_register_lock <= wdat[LOCK_CLR_BIT];
            end
            if (wr_mask) begin
                irq_mask <= wdat[IRQ_W-1:0];
            end
        end
    end

    // Flags: hardware sets win over software clears
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fault_flag <= 1'b0;
            power_on_flag <= POR_RESET;
            force_err_hold <= 1'b0;
            irq_stat <= {IRQ_W{1'b0}};
            irq <= 1'b0;
        end else begin
            fault_flag <= fault_event || (fault_flag && !clear_fault_flags_cmd);
            power_on_flag <= power_on_flag && !clear_power_on_flag_cmd;
            force_err_hold <= force_err_cmd || (force_err_hold && !clear_fault_flags_cmd);
            irq_stat <= next_irq_stat;
            irq <= |(next_irq_stat & irq_mask);
        end
    end

    // Error pin is open drain: enable pulls it low
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            err_pin_oe <= 1'b0;
            err_pin_out <= 1'b0;
            restore_defaults_pulse <= 1'b0;
        end else begin
            err_pin_oe <= force_err_cmd || fault_event ||
                ((force_err_hold || fault_flag) && !clear_fault_flags_cmd);
            err_pin_out <= 1'b0;
            restore_defaults_pulse <= restore_cmd;
        end
    end

    // Pin readback: level changes only when the last two stages agree
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            err_sync <= 3'h7;
            err_level <= 1'b1;
        end else begin
            err_sync <= {err_sync[1:0], err_pin_in};
            if (err_sync[1] == err_sync[2]) begin
                err_level <= err_sync[2];
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_wd_off_hold: assert property (
        state == FWCC_NORMAL && wd_off && !force_fs_cmd |=> state == FWCC_NORMAL)
        else $error("watchdog off yet fail-safe entered");
    a_wd_expire_enter: assert property (
        wd_expired && state == FWCC_NORMAL && !bus_take |=> failsafe_active)
        else $error("watchdog expiry did not enter fail-safe");
    a_direct_enter: assert property (
        state == FWCC_NORMAL && wd_direct |=> state == FWCC_FAILSAFE ##1 failsafe_active)
        else $error("direct fail-safe code ignored");
    a_thr_write: assert property (
        wr_short && !load_pending |=> adc_short_threshold == $past(wdat))
        else $error("threshold write lost");
    a_thr_load: assert property (
        load_pending |=> adc_short_threshold == $past(stored_short_threshold))
        else $error("threshold not loaded from stored copy");
    a_force_fs: assert property (
        force_fs_cmd |=> state == FWCC_FAILSAFE && failsafe_active)
        else $error("force fail-safe ignored");
    a_restore_all: assert property (
        restore_cmd |=> clear_register_lock && irq_mask == IRQ_MASK_RESET
            && restore_defaults_pulse ##1 !restore_defaults_pulse)
        else $error("restore defaults incomplete");
    a_force_err: assert property (
        force_err_cmd |=> err_pin_oe && !err_pin_out)
        else $error("error pin not forced low");
    a_leave_fs: assert property (
        state == FWCC_FAILSAFE && leave_fs_cmd && !force_fs_cmd |=> !failsafe_active)
        else $error("leave fail-safe ignored");
    a_clear_faults: assert property (
        clear_fault_flags_cmd && !fault_event |=> !fault_flag)
        else $error("fault flag survived clear");
    a_clear_por: assert property (
        clear_power_on_flag_cmd |=> !power_on_flag)
        else $error("power-on flag survived clear");
    a_lock_blocks: assert property (
        wr_clr && clear_register_lock && state == FWCC_NORMAL && !wd_direct
            && !(wd_expired && !bus_take) |=> state == FWCC_NORMAL)
        else $error("locked clear register acted");
    a_clr_reads_zero: assert property (
        rd_take && idx == IDX_CLR |=> wb_ack_o && wb_dat_o == 32'h0)
        else $error("command bits read non-zero");

    // Bus handshake: one ack per take, never two in a row
    a_ack_follows: assert property (
        bus_take |=> wb_ack_o)
        else $error("take not acknowledged");
    a_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // Watchdog restart and disable
    a_wd_restart: assert property (
        bus_take |=> !wd_expired)
        else $error("watchdog expired right after host access");
    a_wd_disabled: assert property (
        wd_off |-> !wd_expired)
        else $error("disabled watchdog expired");

    // Flags, error pin and state
    a_fault_set: assert property (
        fault_event |=> fault_flag)
        else $error("fault event lost");
    a_err_released: assert property (
        !force_err_cmd && !fault_event && !force_err_hold && !fault_flag |=> !err_pin_oe)
        else $error("error pin pulled low without cause");
    a_por_sticky: assert property (
        !power_on_flag |=> !power_on_flag)
        else $error("power-on flag set again");
    a_fs_sticky: assert property (
        state == FWCC_FAILSAFE && !leave_fs_cmd |=> state == FWCC_FAILSAFE)
        else $error("fail-safe left without command");

    // Register fields
    a_thr_hold: assert property (
        !wr_short && !restore_cmd && !load_pending |=> $stable(adc_short_threshold))
        else $error("threshold changed without write");
    a_lock_set: assert property (
        wr_lock && wdat[LOCK_CLR_BIT] |=> clear_register_lock)
        else $error("lock bit not set by write");
    a_lock_clear: assert property (
        wr_lock && !wdat[LOCK_CLR_BIT] |=> !clear_register_lock)
        else $error("lock bit not cleared by write");
    a_mask_write: assert property (
        wr_mask |=> irq_mask == IRQ_W'($past(wdat)))
        else $error("mask write lost");

    // Interrupt status and line
    a_stat_sticky: assert property (
        !rd_stat |=> (irq_stat & $past(irq_stat)) == $past(irq_stat))
        else $error("status bit dropped without read");
    a_stat_clear: assert property (
        rd_stat && irq_set == {IRQ_W{1'b0}} |=> irq_stat == {IRQ_W{1'b0}})
        else $error("status read did not clear");
    a_irq_quiet: assert property (
        irq_stat == {IRQ_W{1'b0}} |-> !irq)
        else $error("interrupt without status");
    a_irq_level: assert property (
        $stable(irq_mask) |-> irq == |(irq_stat & irq_mask))
        else $error("interrupt level wrong");
endmodule // fwcc_ctrl

/* sim/tb.sv */
// Self-checking bench for the fail-safe, watchdog and clear/force control block.
// Assumes the package and design sources from hdl/ are compiled first; drives all ports itself.
`timescale 1ns/1ps
module tb;
    import fwcc_pkg::*;
    // Short tick keeps the longest tested timeout near ten thousand cycles
    localparam int TICK = 2;
    localparam int WD_US [5] = '{200, 500, 1000, 2000, 5000};
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [ADR_W-1:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [DAT_W-1:0] wb_dat_i = '0;
    logic [DAT_W-1:0] wb_dat_o;
    logic wb_ack_o, err_pin_out, err_pin_oe, failsafe_active, restore_defaults_pulse, irq;
    logic [REG_W-1:0] stored_short_threshold = 8'h00;
    logic [REG_W-1:0] adc_short_threshold;
    logic [WDSEL_W-1:0] stored_watchdog_select = 4'h0;
    logic fault_event = 1'b0;
    // Open-drain error pin with a pull-up
    wire logic err_pin_in = err_pin_oe ? 1'b0 : 1'b1;
    logic [7:0] rdq[$];
    logic [31:0] seed = 32'h5cdc;
    logic saw_restore = 1'b0;
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;

    fwcc_ctrl #(.TICK_CYCLES(TICK)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .stored_short_threshold(stored_short_threshold),
        .stored_watchdog_select(stored_watchdog_select), .fault_event(fault_event),
        .err_pin_in(err_pin_in), .err_pin_out(err_pin_out), .err_pin_oe(err_pin_oe),
        .failsafe_active(failsafe_active), .adc_short_threshold(adc_short_threshold),
        .restore_defaults_pulse(restore_defaults_pulse), .irq(irq));

    always #5 clk_sys = ~clk_sys;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Request held until ack is sampled high or 50 cycles pass; released at that edge
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) chk("bus ack", 1, 0);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        rdq.push_back(e);
        wb(1'b0, idx, 8'h00);
    endtask

    task automatic look(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic fs_within(input int lim);
        int n;
        n = 0;
        while (failsafe_active !== 1'b1 && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
        chk("fail-safe entry", 1, failsafe_active);
    endtask

    // Watches the bus and takes the oldest expected read value at each read ack
    always @(posedge clk_sys) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            if (rdq.size() == 0) begin
                chk("read queue", 1, 0);
            end else begin
                chk("read data", {24'h0, rdq.pop_front()}, wb_dat_o);
            end
        end
        if (restore_defaults_pulse === 1'b1) saw_restore <= 1'b1;
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_fail++;
            conclude();
        end
    end

    initial begin
        logic [3:0] c;
        logic [7:0] thr;
        seed = lfsr(seed);
        stored_short_threshold <= seed[7:0];
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        look(6);
        chk("threshold", {24'h0, stored_short_threshold}, {24'h0, adc_short_threshold});
        rd(IDX_SHORT, stored_short_threshold);
        rd(IDX_LOCK, 8'h08);
        rd(IDX_STATE, 8'h0c);
        rd(8'h3f, 8'h00);
        wr(8'h3f, 8'hff);
        seed = lfsr(seed);
        thr = seed[7:0];
        wr(IDX_SHORT, thr);
        rd(IDX_SHORT, thr);
        wr(IDX_CLR, 8'h20);
        look(2);
        chk("locked force", 0, failsafe_active);
        wr(IDX_LOCK, 8'h00);
        rd(IDX_LOCK, 8'h00);
        rd(IDX_IRQ_STAT, 8'h00);
        wr(IDX_IRQ_MASK, 8'h01);
        wr(IDX_CLR, 8'h20);
        look(2);
        chk("forced fail-safe", 1, failsafe_active);
        chk("irq raised", 1, irq);
        rd(IDX_CLR, 8'h00);
        rd(IDX_IRQ_STAT, 8'h01);
        look(2);
        chk("irq cleared", 0, irq);
        wr(IDX_CLR, 8'h04);
        look(2);
        chk("left fail-safe", 0, failsafe_active);
        wr(IDX_CLR, 8'h08);
        look(4);
        chk("error pin enable", 1, err_pin_oe);
        chk("error pin level", 0, err_pin_out);
        @(posedge clk_sys);
        fault_event <= 1'b1;
        @(posedge clk_sys);
        fault_event <= 1'b0;
        look(4);
        rd(IDX_STATE, 8'h06);
        chk("masked irq", 0, irq);
        wr(IDX_CLR, 8'h02);
        look(4);
        chk("error pin released", 0, err_pin_oe);
        wr(IDX_CLR, 8'h01);
        rd(IDX_STATE, 8'h08);
        rd(IDX_IRQ_STAT, 8'h02);
        for (int i = 0; i < 5; i++) begin
            c = 4'(i + 1);
            wr(IDX_WDOG, {c, 4'h0});
            wr(IDX_CLR, 8'h04);
            repeat (WD_US[i] * TICK - 10) @(posedge clk_sys);
            chk("watchdog early", 0, failsafe_active);
            fs_within(25);
        end
        wr(IDX_WDOG, 8'h10);
        wr(IDX_CLR, 8'h04);
        repeat (300) @(posedge clk_sys);
        rd(IDX_WDOG, 8'h10);
        repeat (300) @(posedge clk_sys);
        chk("watchdog restarted", 0, failsafe_active);
        fs_within(130);
        wr(IDX_WDOG, 8'h00);
        wr(IDX_CLR, 8'h04);
        for (int k = 12; k < 16; k++) begin
            c = 4'(k);
            wr(IDX_WDOG, {c, 4'h0});
            fs_within(5);
            wr(IDX_WDOG, 8'h00);
            wr(IDX_CLR, 8'h04);
            look(2);
            chk("zero code leave", 0, failsafe_active);
        end
        repeat (1000) @(posedge clk_sys);
        chk("watchdog off", 0, failsafe_active);
        seed = lfsr(seed);
        stored_short_threshold <= seed[7:0];
        stored_watchdog_select <= 4'h2;
        wr(IDX_CLR, 8'h10);
        look(2);
        chk("restore pulse", 1, saw_restore);
        chk("restored threshold", {24'h0, seed[7:0]}, {24'h0, adc_short_threshold});
        rd(IDX_WDOG, 8'h20);
        rd(IDX_LOCK, 8'h08);
        rd(IDX_CLR, 8'h00);
        wr(IDX_CLR, 8'h20);
        look(2);
        chk("relocked force", 0, failsafe_active);
        conclude();
    end
endmodule // tb
